// file: cgr_config_regs.sv
// file holds the top module of the low configuration register bank
// assumes the serial engine gives one-cycle write/read strobes
`include "cgr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cgr_config_regs #(
  parameter logic [7:0] PART_IDENTIFIER = `CGR_PART_IDENTIFIER_DEF // arbitrary value
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial port request
  input wire cgr_pkg::cgr_req_t req,
  input wire logic ioUpdate,
  // read answer
  output logic [7:0] rdData,
  output logic rdValid,
  // active bank to the clock generator
  output cgr_pkg::cgr_bank_t active
);
  cgr_pkg::cgr_bank_t buffer;
  cgr_pkg::cgr_bank_t shownBank;
  cgr_pkg::cgr_bank_t defaults;
  logic selPortCfg, selPartId, selReadback, selVerLo, selVerHi;
  logic selPump, selRefLo, selRefHi;
  logic softRst;
  logic [7:0] readMux;

  cgr_decode uDecode (
    .addr(req.addr),
    .selPortCfg(selPortCfg),
    .selPartId(selPartId),
    .selReadback(selReadback),
    .selVerLo(selVerLo),
    .selVerHi(selVerHi),
    .selPump(selPump),
    .selRefLo(selRefLo),
    .selRefHi(selRefHi)
  );

  // reset image of the bank, one driver for the whole word
  assign defaults = '{
    portCfg: `CGR_RST_PORTCFG,
    readbackActive: 1'b0,
    userVersion: {`CGR_RST_VER, `CGR_RST_VER},
    pumpCtrl: `CGR_RST_PUMP,
    refDivider: {`CGR_RST_REFHI, `CGR_RST_REFLO}
  };

  // soft reset fires on a write setting either mirrored bit
  assign softRst = req.wrEn && selPortCfg &&
    ((req.wrData & `CGR_SOFTRST_MASK) != `CGR_ZERO8);

  // buffer bank: only mapped writes land, unused bits are dropped
  // a soft reset wins over the write that carries it, so the self-clearing
  // bits are never stored and always read back as zero
  always_ff @(posedge clock) begin
    if (sys_rst || softRst) begin
      buffer <= defaults;
    end else if (req.wrEn) begin
      if (selPortCfg) begin
        buffer.portCfg <= req.wrData & `CGR_PORTCFG_KEEP;
      end
      if (selReadback) begin
        buffer.readbackActive <= req.wrData[`CGR_READBACK_BIT];
      end
      if (selVerLo) begin
        buffer.userVersion[7:0] <= req.wrData;
      end
      if (selVerHi) begin
        buffer.userVersion[15:8] <= req.wrData;
      end
      if (selPump) begin
        buffer.pumpCtrl <= req.wrData;
      end
      if (selRefLo) begin
        buffer.refDivider[7:0] <= req.wrData;
      end
      if (selRefHi) begin
        buffer.refDivider[13:8] <= req.wrData[`CGR_REFHI_W-1:0];
      end
    end
  end

  // active bank follows the buffer only on an update strobe
  always_ff @(posedge clock) begin
    if (sys_rst || softRst) begin
      active <= defaults;
    end else if (ioUpdate) begin
      active <= buffer;
    end
  end

  // readback select itself is taken from the buffer so it acts at once
  assign shownBank = buffer.readbackActive ? active : buffer;
  assign readMux =
    selPortCfg ? shownBank.portCfg :
    selPartId ? PART_IDENTIFIER :
    selReadback ? {7'h00, buffer.readbackActive} :
    selVerLo ? shownBank.userVersion[7:0] :
    selVerHi ? shownBank.userVersion[15:8] :
    selPump ? shownBank.pumpCtrl :
    selRefLo ? shownBank.refDivider[7:0] :
    selRefHi ? {2'h0, shownBank.refDivider[13:8]} :
    `CGR_ZERO8;

  // registered read answer, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdData <= `CGR_ZERO8;
      rdValid <= 1'b0;
    end else begin
      rdData <= req.rdEn ? readMux : `CGR_ZERO8;
      rdValid <= req.rdEn;
    end
  end

  // independent view of the map for the checks below, kept apart from the
  // decoder so that a decoding slip cannot hide itself
  logic hitWritable;
  logic hitMapped;
  assign hitWritable = (req.addr == `CGR_A_PORTCFG) ||
    (req.addr == `CGR_A_READBACK) ||
    (req.addr == `CGR_A_VERLO) ||
    (req.addr == `CGR_A_VERHI) ||
    (req.addr == `CGR_A_PUMP) ||
    (req.addr == `CGR_A_REFLO) ||
    (req.addr == `CGR_A_REFHI);
  assign hitMapped = hitWritable || (req.addr == `CGR_A_PARTID);

  // a write that misses every writable slot leaves the buffer untouched
  AST_UNMAPPED: assert property (
    @(posedge clock) disable iff (sys_rst)
    (req.wrEn && !hitWritable) |=> $stable(buffer))
    else $error("unmapped write changed buffer");

  // a read off the map answers with a zero byte
  AST_READ_UNMAPPED: assert property (
    @(posedge clock) disable iff (sys_rst)
    (req.rdEn && !hitMapped) |=> rdData == `CGR_ZERO8)
    else $error("unmapped read returned data");

  // port config bits that the map leaves unused never hold a one in either bank
  AST_UNUSED_BITS: assert property (
    @(posedge clock) disable iff (sys_rst)
    (buffer.portCfg & ~`CGR_PORTCFG_KEEP) == `CGR_ZERO8 &&
    (active.portCfg & ~`CGR_PORTCFG_KEEP) == `CGR_ZERO8)
    else $error("unused bits held state");

  // the upper divider byte keeps its six low bits and drops the rest
  AST_REFHI: assert property (
    @(posedge clock) disable iff (sys_rst)
    (req.wrEn && req.addr == `CGR_A_REFHI) |=>
      buffer.refDivider[13:8] == $past(req.wrData[`CGR_REFHI_W-1:0]))
    else $error("divider high byte not stored");

  // readback bit set: reads show the active bank
  AST_READ_ACTIVE: assert property (
    @(posedge clock) disable iff (sys_rst)
    (req.rdEn && req.addr == `CGR_A_VERLO && buffer.readbackActive) |=>
      rdData == $past(active.userVersion[7:0]))
    else $error("readback did not show active bank");

  // readback bit clear: reads show the buffer bank
  AST_READ_BUFFER: assert property (
    @(posedge clock) disable iff (sys_rst)
    (req.rdEn && req.addr == `CGR_A_VERLO && !buffer.readbackActive) |=>
      rdData == $past(buffer.userVersion[7:0]))
    else $error("readback did not show buffer bank");

  // the readback register itself shows its one stored bit
  AST_READBACK_BIT: assert property (
    @(posedge clock) disable iff (sys_rst)
    (req.rdEn && req.addr == `CGR_A_READBACK) |=>
      rdData == {7'h00, $past(buffer.readbackActive)})
    else $error("readback bit read wrong");

  // a hard reset leaves the divider at its start value of one
  AST_REFDIV: assert property (
    @(posedge clock)
    sys_rst |=> buffer.refDivider == {`CGR_RST_REFHI, `CGR_RST_REFLO})
    else $error("divider reset wrong");

  // the high half of the version word lands in its own byte
  AST_VERSION: assert property (
    @(posedge clock) disable iff (sys_rst)
    (req.wrEn && req.addr == `CGR_A_VERHI) |=>
      buffer.userVersion[15:8] == $past(req.wrData))
    else $error("version high byte not stored");

  // the low half of the version word lands in its own byte
  AST_VERSION_LO: assert property (
    @(posedge clock) disable iff (sys_rst)
    (req.wrEn && req.addr == `CGR_A_VERLO) |=>
      buffer.userVersion[7:0] == $past(req.wrData))
    else $error("version low byte not stored");

  // a soft reset restores both banks and its own bits read back as zero
  AST_SOFTRST: assert property (
    @(posedge clock) disable iff (sys_rst)
    (req.wrEn && req.addr == `CGR_A_PORTCFG &&
     (req.wrData & `CGR_SOFTRST_MASK) != `CGR_ZERO8) |=>
      buffer == defaults && active == defaults)
    else $error("soft reset did not restore");

  // an update strobe copies the whole buffer bank across
  AST_UPDATE: assert property (
    @(posedge clock) disable iff (sys_rst)
    (ioUpdate && !softRst) |=> active == $past(buffer))
    else $error("update did not copy");

  // without a strobe or a soft reset the active bank never moves
  AST_HOLD: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!ioUpdate && !softRst) |=> $stable(active))
    else $error("active changed without update");
endmodule
`default_nettype wire

// file: cgr_regs.svh
// register map constants for the low configuration bank
// assumes byte-wide serial register access with 12-bit addresses
`ifndef CGR_REGS_SVH
`define CGR_REGS_SVH
`define CGR_ADDR_W 12
`define CGR_A_PORTCFG 12'h000
`define CGR_A_PARTID 12'h003
`define CGR_A_READBACK 12'h004
`define CGR_A_VERLO 12'h005
`define CGR_A_VERHI 12'h006
`define CGR_A_PUMP 12'h010
`define CGR_A_REFLO 12'h011
`define CGR_A_REFHI 12'h012
`define CGR_RST_PORTCFG 8'h00
`define CGR_RST_READBACK 8'h00
`define CGR_RST_VER 8'h00
`define CGR_RST_PUMP 8'h7D
`define CGR_RST_REFLO 8'h01
`define CGR_RST_REFHI 6'h00
`define CGR_PART_IDENTIFIER_DEF 8'h5A
`define CGR_SOFTRST_MASK 8'h24
`define CGR_PORTCFG_KEEP 8'hC3
`define CGR_READBACK_BIT 0
`define CGR_REFHI_W 6
`define CGR_ZERO8 8'h00
`endif

// file: cgr_pkg.sv
// types shared by the low configuration bank
// assumes cgr_regs.svh is included by users that need numbers
package cgr_pkg;
  typedef struct packed {
    logic [7:0] portCfg;
    logic readbackActive;
    logic [15:0] userVersion;
    logic [7:0] pumpCtrl;
    logic [13:0] refDivider;
  } cgr_bank_t;
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [11:0] addr;
    logic [7:0] wrData;
  } cgr_req_t;
endpackage

// file: cgr_decode.sv
// address decoder for the low configuration bank
// assumes addresses come from the serial port engine
`include "cgr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cgr_decode (
  // address in
  input wire logic [11:0] addr,
  // one-hot selects
  output logic selPortCfg,
  output logic selPartId,
  output logic selReadback,
  output logic selVerLo,
  output logic selVerHi,
  output logic selPump,
  output logic selRefLo,
  output logic selRefHi
);
  // unlisted, unused and reserved slots match nothing
  assign selPortCfg = (addr == `CGR_A_PORTCFG);
  assign selPartId = (addr == `CGR_A_PARTID);
  assign selReadback = (addr == `CGR_A_READBACK);
  assign selVerLo = (addr == `CGR_A_VERLO);
  assign selVerHi = (addr == `CGR_A_VERHI);
  assign selPump = (addr == `CGR_A_PUMP);
  assign selRefLo = (addr == `CGR_A_REFLO);
  assign selRefHi = (addr == `CGR_A_REFHI);
endmodule
`default_nettype wire

// file: cgr_host.sv
// host model that issues serial register requests
// assumes the block takes requests on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module cgr_host (
  // clock
  input wire logic clock,
  // requests to the block
  output var cgr_pkg::cgr_req_t req,
  output var logic ioUpdate,
  // read answer
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  initial begin
    req <= '0;
    ioUpdate <= 1'b0;
  end
  // idle bus shows inverted values so a stale byte can never match
  task automatic idle(input logic [11:0] a, input logic [7:0] d);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock) req <= '{1'b1, 1'b0, a, d};
    @(posedge clock) idle(a, d);
  endtask
  // answer is registered, so look one step after the next edge
  task automatic rd(input logic [11:0] a, output logic [8:0] q);
    @(posedge clock) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) idle(a, 8'h00);
    #1 q = {rdValid, rdData};
  endtask
  task automatic upd();
    @(posedge clock) ioUpdate <= 1'b1;
    @(posedge clock) ioUpdate <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// file: clock_gen_config_regs_low_tb.sv
// testbench for the low configuration register bank
// assumes the host model and the design files are compiled first
`include "cgr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module clock_gen_config_regs_low_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  cgr_pkg::cgr_req_t req;
  logic ioUpdate;
  logic [7:0] rdData;
  logic rdValid;
  cgr_pkg::cgr_bank_t active;
  int bad_count = 0;
  int n_compared = 0;
  logic [8:0] q;
  initial forever #50 clock = ~clock;
  cgr_config_regs u_cgr_config_regs (.clock, .sys_rst, .req, .ioUpdate,
    .rdData, .rdValid, .active);
  cgr_host u_cgr_host (.clock, .req, .ioUpdate, .rdData, .rdValid);
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // a read must come back valid with the expected byte
  task automatic rchk(input logic [11:0] r, input logic [7:0] e);
    u_cgr_host.rd(r, q);
    chk({7'h00, q}, {8'h01, e});
  endtask
  task automatic t_defaults();
    rchk(12'h004, 8'h00);
    rchk(12'h005, 8'h00);
    rchk(12'h006, 8'h00);
    rchk(12'h011, 8'h01);
    rchk(12'h012, 8'h00);
    chk(active.refDivider, 16'h0001);
  endtask
  // a write of all ones into an unwritable slot stores nothing and the slot reads back as the given byte
  task automatic spare(input logic [11:0] r, input logic [7:0] e);
    u_cgr_host.wr(r, 8'hFF);
    rchk(r, e);
  endtask
  // writes off the map, into spare slots or into the read-only part slot must leave everything alone; unused port bits are dropped
  task automatic t_unmapped();
    spare(12'h001, 8'h00);
    spare(12'h002, 8'h00);
    spare(12'h003, `CGR_PART_IDENTIFIER_DEF);
    spare(12'h007, 8'h00);
    spare(12'h00F, 8'h00);
    spare(12'hFFF, 8'h00);
    rchk(12'h004, 8'h00);
    rchk(12'h005, 8'h00);
    rchk(12'h010, 8'h7D);
    rchk(12'h011, 8'h01);
    u_cgr_host.wr(12'h000, 8'hDB);
    rchk(12'h000, 8'hC3);
    u_cgr_host.upd();
    chk({8'h00, active.portCfg}, 16'h00C3);
  endtask
  task automatic t_refdiv();
    u_cgr_host.wr(12'h011, 8'hFF);
    u_cgr_host.wr(12'h012, 8'hFF);
    rchk(12'h012, 8'h3F);
    chk(active.refDivider, 16'h0001);
    u_cgr_host.upd();
    chk(active.refDivider, 16'h3FFF);
  endtask
  task automatic t_readback();
    u_cgr_host.wr(12'h005, 8'h34);
    u_cgr_host.wr(12'h006, 8'h12);
    u_cgr_host.upd();
    chk(active.userVersion, 16'h1234);
    u_cgr_host.wr(12'h005, 8'hAA);
    u_cgr_host.wr(12'h004, 8'h01);
    rchk(12'h005, 8'h34);
    u_cgr_host.wr(12'h004, 8'h00);
    rchk(12'h005, 8'hAA);
  endtask
  // a second reset in mid-run, held over two edges, restores the version, readback and divider defaults
  task automatic t_sysrst();
    @(posedge clock) sys_rst <= 1'b1;
    @(posedge clock);
    @(posedge clock) sys_rst <= 1'b0;
    #1 chk(active.userVersion, 16'h0000);
    t_defaults();
  endtask
  // each self-clearing bit on its own restores both banks
  task automatic t_softrst(input logic [7:0] m);
    u_cgr_host.wr(12'h010, 8'h11);
    u_cgr_host.upd();
    u_cgr_host.wr(12'h000, m);
    rchk(12'h000, 8'h00);
    rchk(12'h010, 8'h7D);
    chk(active.pumpCtrl, 16'h007D);
  endtask
  task automatic summarize();
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    t_defaults();
    t_unmapped();
    t_refdiv();
    t_readback();
    t_sysrst();
    t_softrst(8'h20);
    t_softrst(8'h04);
    summarize();
  end
endmodule
`default_nettype wire
